/* File: sim/srf_link_model.sv */
`timescale 1ns/1ps
// Link master: idle-low clock, data set while clock is low
module srf_link_model (
    output logic link_clk_o,
    output logic link_sel_n_o,
    output logic link_data_o
);
    // Idle: deselected, clock standing low
    initial begin
        link_clk_o   = 1'b0;
        link_sel_n_o = 1'b1;
        link_data_o  = 1'b0;
    end
    // Top n bits of a word, MSB first, 200 ns per bit
    task automatic send(input logic [15:0] w, input int n);
        // Start off the system clock's sampling edges
        #7;
        link_sel_n_o = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            link_data_o = w[i];
            #100;
            link_clk_o = 1'b1;
            #100;
            link_clk_o = 1'b0;
        end
        #100;
        link_sel_n_o = 1'b1;
        // Released line shows the opposite of its last bit
        link_data_o = ~link_data_o;
        #100;
    endtask : send
endmodule : srf_link_model

/* File: sim/srf_props.sv */
`timescale 1ns/1ps
// Port checks of register reads and interrupt outputs
module srf_props
    import srf_pkg::*;
(
    input wire logic                  clk_i,
    input wire logic                  reset_n_i,
    input wire logic [SRF_ADDR_W-1:0] addr_i,
    input wire logic [31:0]           wdata_i,
    input wire logic                  wr_i,
    input wire logic                  rd_i,
    input wire logic [31:0]           rdata_o,
    input wire logic                  link_clk_i,
    input wire logic                  link_sel_n_i,
    input wire logic                  link_data_i,
    input wire logic                  irq_o,
    input wire logic                  irq_level_a_o,
    input wire logic                  irq_level_b_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Read strobe aimed at one offset
    sequence s_rd(logic [7:0] a);
        rd_i && addr_i == a;
    endsequence
    property p_idle; !rd_i |=> rdata_o == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_irq; irq_o == (irq_level_a_o | irq_level_b_o); endproperty
    a_irq: assert property (p_irq) else $error("irq not level or");
    property p_veca; s_rd(SRF_OFS_VECA) ##1 $stable(irq_level_a_o)
        |-> (rdata_o[1:0] != 2'h0) == irq_level_a_o; endproperty
    a_veca: assert property (p_veca) else $error("vector a wrong");
    property p_vecb; s_rd(SRF_OFS_VECB) ##1 $stable(irq_level_b_o)
        |-> (rdata_o[1:0] != 2'h0) == irq_level_b_o; endproperty
    a_vecb: assert property (p_vecb) else $error("vector b wrong");
    property p_unmap; rd_i && !(addr_i inside {8'h00, 8'h04, 8'h08,
        8'h0c, 8'h10, 8'h14}) |=> rdata_o == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_hold; s_rd(SRF_OFS_FLAG) ##0 irq_o |=> irq_o; endproperty
    a_hold: assert property (p_hold) else $error("flag lost");
    property p_buf; s_rd(SRF_OFS_BUF) ##1 s_rd(SRF_OFS_FLAG) |=>
        (rdata_o[2:1] & $past(rdata_o[26:25])) == $past(rdata_o[26:25]);
    endproperty
    a_buf: assert property (p_buf) else $error("error lost");
    property p_mask; wr_i && addr_i == SRF_OFS_MASK && wdata_i[2:0] == 3'h0
        |=> !irq_o; endproperty
    a_mask: assert property (p_mask) else $error("irq not masked");
endmodule : srf_props

bind srf_top srf_props i_srf_props (.clk_i, .reset_n_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .link_clk_i, .link_sel_n_i, .link_data_i,
    .irq_o, .irq_level_a_o, .irq_level_b_o);

/* File: sim/srf_top_test.sv */
`timescale 1ns/1ps
// Register port and serial link traffic with self checks
module srf_top_test;
    import srf_pkg::*;
    logic        clk_i;
    logic        reset_n_i;
    logic [7:0]  addr_i;
    logic [31:0] wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [31:0] rdata_o;
    logic        link_clk_i;
    logic        link_sel_n_i;
    logic        link_data_i;
    logic        irq_o;
    logic        irq_level_a_o;
    logic        irq_level_b_o;
    logic [31:0] r0;
    logic [31:0] r1;
    logic [15:0] w;
    logic [1:0]  ex;
    int          err_count;
    int          check_count;

    srf_top i_srf_top (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .link_clk_i, .link_sel_n_i, .link_data_i, .irq_o,
        .irq_level_a_o, .irq_level_b_o);
    srf_link_model i_srf_link_model (.link_clk_o(link_clk_i),
        .link_sel_n_o(link_sel_n_i), .link_data_o(link_data_i));

    // Buffer word: status copy above received data
    function automatic logic [31:0] buf_exp(logic [2:0] f, logic [15:0] d);
        return {5'h0, f, 8'h0, d};
    endfunction : buf_exp

    // Flags after a buffer read b raced by new word nw, f read next
    function automatic logic [1:0] race_exp(logic [31:0] b,
                                            logic [31:0] f,
                                            logic [15:0] nw);
        logic late;
        late = (b[15:0] == nw);
        return {late | f[SRF_BIT_RXC], !late};
    endfunction : race_exp

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr

    // Two reads back to back, answers into r0 then r1
    task automatic rd(input logic [7:0] a0, input logic [7:0] a1);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= a0;
        @(posedge clk_i);
        addr_i <= a1;
        #1;
        r0 = rdata_o;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        r1 = rdata_o;
    endtask : rd

    task automatic settle;
        repeat (12) @(posedge clk_i);
    endtask : settle

    task automatic conclude;
        if (err_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        conclude;
    end

    initial begin
        reset_n_i   = 1'b0;
        addr_i      = 8'h0;
        wdata_i     = 32'h0;
        wr_i        = 1'b0;
        rd_i        = 1'b0;
        err_count   = 0;
        check_count = 0;
        void'($urandom(32'h6da25d15));
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        settle;
        // Reset values; unmapped place ignores writes
        wr(8'h18, 32'hffff_ffff);
        for (int i = 1; i < 7; i++) begin
            rd(8'(i * 4), 8'h18);
            chk(r0 | r1, 32'h0);
        end
        // One word; buffer read clears the receive flag
        w = 16'($urandom);
        i_srf_link_model.send(w, 16);
        settle;
        rd(SRF_OFS_BUF, SRF_OFS_FLAG);
        chk(r0, buf_exp(3'h1, w));
        chk({16'h0, r0[15:0]}, {16'h0, w});
        chk(r1, 32'h0);
        // Two unread words: overrun, newer word kept
        i_srf_link_model.send(~w, 16);
        i_srf_link_model.send(w, 16);
        settle;
        rd(SRF_OFS_FLAG, SRF_OFS_BUF);
        chk(r0, 32'h3);
        chk(r1, buf_exp(3'h3, w));
        // Clear overrun, read back, clear again if still set
        wr(SRF_OFS_FLAG, 32'h2);
        rd(SRF_OFS_FLAG, SRF_OFS_FLAG);
        if (r0[1]) wr(SRF_OFS_FLAG, 32'h2);
        chk(r0, 32'h0);
        // Short frame, then errors on level B, receive on A
        i_srf_link_model.send(w, 5);
        wr(SRF_OFS_LEVEL, 32'h6);
        wr(SRF_OFS_MASK, 32'h7);
        i_srf_link_model.send(w, 16);
        settle;
        rd(SRF_OFS_VECA, SRF_OFS_VECB);
        chk(r0, {30'h0, SRF_VEC_RXC});
        chk(r1, {30'h0, SRF_VEC_BER});
        rd(SRF_OFS_FLAG, SRF_OFS_LEVEL);
        chk({23'h0, r0[2:0], r1[2:0], irq_o, irq_level_a_o,
            irq_level_b_o}, 32'h177);
        // Mask drops the interrupt; clear flags and unmask
        wr(SRF_OFS_MASK, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        wr(SRF_OFS_FLAG, 32'h7);
        wr(SRF_OFS_MASK, 32'h7);
        rd(SRF_OFS_MASK, SRF_OFS_FLAG);
        chk({25'h0, r0[2:0], r1[2:0], irq_o}, 32'h70);
        // Sweep reads across the completion of an overrunning word
        for (int d = 0; d < 12; d++) begin
            w = 16'($urandom);
            i_srf_link_model.send(w, 16);
            settle;
            fork
                i_srf_link_model.send(~w, 16);
                begin
                    repeat (16) @(posedge link_clk_i);
                    repeat (d) @(posedge clk_i);
                    rd(d[0] ? SRF_OFS_FLAG : SRF_OFS_BUF, SRF_OFS_FLAG);
                end
            join
            ex = race_exp(r0, r1, ~w);
            settle;
            rd(SRF_OFS_FLAG, SRF_OFS_BUF);
            if (d[0]) chk(r0, 32'h3);
            else chk(r0, {30'h0, ex});
            wr(SRF_OFS_FLAG, 32'h7);
        end
        // Overrun clear swept across a new word's arrival
        for (int d = 0; d < 6; d++) begin
            i_srf_link_model.send(w, 16);
            i_srf_link_model.send(~w, 16);
            wr(SRF_OFS_FLAG, 32'h1);
            fork
                i_srf_link_model.send(w, 16);
                begin
                    repeat (16) @(posedge link_clk_i);
                    repeat (d) @(posedge clk_i);
                    wr(SRF_OFS_FLAG, 32'h2);
                end
            join
            settle;
            rd(SRF_OFS_FLAG, SRF_OFS_BUF);
            chk(r0, 32'h1);
            wr(SRF_OFS_FLAG, 32'h7);
        end
        conclude;
    end
endmodule : srf_top_test

/* File: src/srf_pkg.sv */
package srf_pkg;
    // Word and field widths
    localparam int          SRF_WORD_W     = 16;
    localparam int          SRF_ADDR_W     = 8;
    localparam int          SRF_CNT_W      = 5;
    localparam int          SRF_VEC_W      = 2;
    localparam int          SRF_NSRC       = 3;
    // Register byte offsets
    localparam logic [7:0]  SRF_OFS_BUF    = 8'h00;
    localparam logic [7:0]  SRF_OFS_FLAG   = 8'h04;
    localparam logic [7:0]  SRF_OFS_LEVEL  = 8'h08;
    localparam logic [7:0]  SRF_OFS_MASK   = 8'h0c;
    localparam logic [7:0]  SRF_OFS_VECA   = 8'h10;
    localparam logic [7:0]  SRF_OFS_VECB   = 8'h14;
    // Flag bit positions, shared by flag, level and mask registers
    localparam int          SRF_BIT_RXC    = 0;
    localparam int          SRF_BIT_OVR    = 1;
    localparam int          SRF_BIT_BER    = 2;
    // Status copy position inside the buffer word
    localparam int          SRF_BUF_STAT_LSB = 24;
    // Vector codes, zero means nothing pending
    localparam logic [1:0]  SRF_VEC_NONE   = 2'h0;
    localparam logic [1:0]  SRF_VEC_BER    = 2'h1;
    localparam logic [1:0]  SRF_VEC_OVR    = 2'h2;
    localparam logic [1:0]  SRF_VEC_RXC    = 2'h3;
    // Reset values
    localparam logic [2:0]  SRF_FLAG_RST   = 3'h0;
    localparam logic [2:0]  SRF_LEVEL_RST  = 3'h0;
    localparam logic [2:0]  SRF_MASK_RST   = 3'h0;
    localparam logic [31:0] SRF_ZERO32     = 32'h0000_0000;
endpackage : srf_pkg

/* File: src/srf_rx_shift.sv */
`timescale 1ns/1ps
// Serial receiver: samples link pins, shifts bits on rising link clock
module srf_rx_shift
    import srf_pkg::*;
#(
    parameter int WORD_W = SRF_WORD_W
) (
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    input  wire logic              link_clk_i,
    input  wire logic              link_sel_n_i,
    input  wire logic              link_data_i,
    output logic [WORD_W-1:0]      word_o,
    output logic                   word_done_o,
    output logic                   frame_err_o
);
    // Two-stage synchronisers, first stage read only by second
    logic [2:0]        meta_r;
    logic [2:0]        sync_r;
    logic [2:0]        meta_nxt;
    logic [2:0]        sync_nxt;
    // Previous link clock and select, for edge finding
    logic              clk_prev_r;
    logic              sel_prev_r;
    // Shift register, bit count and outputs
    logic [WORD_W-1:0] shift_r;
    logic [WORD_W-1:0] shift_nxt;
    logic [SRF_CNT_W-1:0] cnt_r;
    logic [SRF_CNT_W-1:0] cnt_nxt;
    logic [WORD_W-1:0] word_nxt;
    logic              done_nxt;
    logic              err_nxt;
    logic              rise;
    logic              active;

    // Next-state: sync, edge detect, shift, word and frame checks
    always_comb begin
        meta_nxt  = {link_clk_i, link_sel_n_i, link_data_i};
        sync_nxt  = meta_r;
        active    = ~sync_r[1];
        rise      = sync_r[2] & ~clk_prev_r & active;
        shift_nxt = shift_r;
        cnt_nxt   = cnt_r;
        word_nxt  = word_o;
        done_nxt  = 1'b0;
        err_nxt   = 1'b0;
        if (!active) begin
            // Select high: partial word is a framing bit error
            cnt_nxt = '0;
            if (!sel_prev_r && cnt_r != '0) begin
                err_nxt = 1'b1;
            end
        end else if (rise) begin
            // MSB first
            shift_nxt = {shift_r[WORD_W-2:0], sync_r[0]};
            if (cnt_r == SRF_CNT_W'(WORD_W - 1)) begin
                cnt_nxt  = '0;
                word_nxt = {shift_r[WORD_W-2:0], sync_r[0]};
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + SRF_CNT_W'(1);
            end
        end
    end

    // Registers only
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_r      <= 3'h2;
            sync_r      <= 3'h2;
            clk_prev_r  <= 1'b0;
            sel_prev_r  <= 1'b1;
            shift_r     <= '0;
            cnt_r       <= '0;
            word_o      <= '0;
            word_done_o <= 1'b0;
            frame_err_o <= 1'b0;
        end else begin
            meta_r      <= meta_nxt;
            sync_r      <= sync_nxt;
            clk_prev_r  <= sync_r[2];
            sel_prev_r  <= sync_r[1];
            shift_r     <= shift_nxt;
            cnt_r       <= cnt_nxt;
            word_o      <= word_nxt;
            word_done_o <= done_nxt;
            frame_err_o <= err_nxt;
        end
    end
endmodule : srf_rx_shift

/* File: src/srf_top.sv */
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
// Function
// - Flag register read never drops new error flags
// - Buffer status read never drops error flags
// - Buffer read clears receive flag, set wins
// - Overrun write-clear lost to receive set only when a word lands over an unread one
// - Overrun always set, even during buffer read
// - Two interrupt levels, one vector each
module srf_top
    import srf_pkg::*;
#(
    parameter int WORD_W = SRF_WORD_W
) (
    input  wire logic                  clk_i,
    input  wire logic                  reset_n_i,
    // Register port
    input  wire logic [SRF_ADDR_W-1:0] addr_i,
    input  wire logic [31:0]           wdata_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    output logic [31:0]                rdata_o,
    // Serial link pins
    input  wire logic                  link_clk_i,
    input  wire logic                  link_sel_n_i,
    input  wire logic                  link_data_i,
    // Interrupts
    output logic                       irq_o,
    output logic                       irq_level_a_o,
    output logic                       irq_level_b_o
);
    // Flag, level select, mask and receive buffer state
    logic [SRF_NSRC-1:0] flag_r;
    logic [SRF_NSRC-1:0] flag_nxt;
    logic [SRF_NSRC-1:0] level_r;
    logic [SRF_NSRC-1:0] level_nxt;
    logic [SRF_NSRC-1:0] mask_r;
    logic [SRF_NSRC-1:0] mask_nxt;
    logic [WORD_W-1:0]   buf_r;
    logic [WORD_W-1:0]   buf_nxt;
    logic [31:0]         rdata_nxt;
    logic                irq_nxt;
    logic                irq_a_nxt;
    logic                irq_b_nxt;
    // Receiver outputs
    logic [WORD_W-1:0]   rx_word;
    logic                rx_done;
    logic                rx_err;
    // Event and clear terms
    logic [SRF_NSRC-1:0] set_ev;
    logic [SRF_NSRC-1:0] clr_ev;
    logic [SRF_NSRC-1:0] pend;
    logic [1:0]          vec_a;
    logic [1:0]          vec_b;
    // Register strobes decoded against their offsets
    logic                wr_flag;
    logic                wr_level;
    logic                wr_mask;
    logic                rd_buf;

    // Highest-priority pending source of one level; errors first
    function automatic logic [1:0] srf_vector(
        input logic [SRF_NSRC-1:0] p,
        input logic [SRF_NSRC-1:0] sel
    );
        logic [SRF_NSRC-1:0] m;
        m = p & sel;
        if (m[SRF_BIT_BER]) begin
            srf_vector = SRF_VEC_BER;
        end else if (m[SRF_BIT_OVR]) begin
            srf_vector = SRF_VEC_OVR;
        end else if (m[SRF_BIT_RXC]) begin
            srf_vector = SRF_VEC_RXC;
        end else begin
            srf_vector = SRF_VEC_NONE;
        end
    endfunction : srf_vector

    // One strobe aimed at one register offset
    function automatic logic srf_hit(
        input logic                  strobe,
        input logic [SRF_ADDR_W-1:0] a,
        input logic [SRF_ADDR_W-1:0] ofs
    );
        srf_hit = strobe && (a == ofs);
    endfunction : srf_hit

    // Link receiver
    srf_rx_shift #(
        .WORD_W       (WORD_W)
    ) u_rx (
        .clk_i        (clk_i),
        .reset_n_i    (reset_n_i),
        .link_clk_i   (link_clk_i),
        .link_sel_n_i (link_sel_n_i),
        .link_data_i  (link_data_i),
        .word_o       (rx_word),
        .word_done_o  (rx_done),
        .frame_err_o  (rx_err)
    );

    // Strobe decode, shared by flag and control logic
    always_comb begin
        wr_flag  = srf_hit(wr_i, addr_i, SRF_OFS_FLAG);
        wr_level = srf_hit(wr_i, addr_i, SRF_OFS_LEVEL);
        wr_mask  = srf_hit(wr_i, addr_i, SRF_OFS_MASK);
        // Only buffer reads have a side effect
        rd_buf   = srf_hit(rd_i, addr_i, SRF_OFS_BUF);
    end

    // Flag set and clear terms
    always_comb begin
        set_ev = '0;
        clr_ev = '0;
        // New word raises receive flag
        set_ev[SRF_BIT_RXC] = rx_done;
        // New word over unread word: overrun, whatever bus does
        set_ev[SRF_BIT_OVR] = rx_done & flag_r[SRF_BIT_RXC];
        // Cut frame raises the bit error flag
        set_ev[SRF_BIT_BER] = rx_err;
        // Buffer read clears receive flag
        if (rd_buf) begin
            clr_ev[SRF_BIT_RXC] = 1'b1;
        end
        // Flag register reads are not decoded: they never clear
        // Write one to clear any flag
        if (wr_flag) begin
            clr_ev = wdata_i[SRF_NSRC-1:0];
        end
    end

    // Next values of flags, control and buffer
    always_comb begin
        // Set beats clear; reads alone never touch error flags
        flag_nxt  = set_ev | (flag_r & ~clr_ev);
        level_nxt = level_r;
        mask_nxt  = mask_r;
        // Newest word always lands, even over an unread one
        buf_nxt   = rx_done ? rx_word : buf_r;
        // Level select held unless written
        if (wr_level) begin
            level_nxt = wdata_i[SRF_NSRC-1:0];
        end
        // Mask held unless written
        if (wr_mask) begin
            mask_nxt = wdata_i[SRF_NSRC-1:0];
        end
    end

    // Pending interrupts and per-level vectors
    always_comb begin
        pend  = flag_r & mask_r;
        // Level select bit low: level A, high: level B
        vec_a = srf_vector(pend, ~level_r);
        vec_b = srf_vector(pend, level_r);
        // Next values, so interrupts move with the flags
        irq_a_nxt = |(flag_nxt & mask_nxt & ~level_nxt);
        irq_b_nxt = |(flag_nxt & mask_nxt & level_nxt);
        irq_nxt   = |(flag_nxt & mask_nxt);
    end

    // Read data mux, answered one cycle after strobe
    always_comb begin
        rdata_nxt = SRF_ZERO32;
        if (rd_i) begin
            case (addr_i)
                SRF_OFS_BUF: begin
                    // Status copy above the data; errors untouched
                    rdata_nxt[WORD_W-1:0] = buf_r;
                    rdata_nxt[SRF_BUF_STAT_LSB +: SRF_NSRC] = flag_r;
                end
                SRF_OFS_FLAG: begin
                    rdata_nxt[SRF_NSRC-1:0] = flag_r;
                end
                SRF_OFS_LEVEL: begin
                    rdata_nxt[SRF_NSRC-1:0] = level_r;
                end
                SRF_OFS_MASK: begin
                    rdata_nxt[SRF_NSRC-1:0] = mask_r;
                end
                SRF_OFS_VECA: begin
                    rdata_nxt[SRF_VEC_W-1:0] = vec_a;
                end
                SRF_OFS_VECB: begin
                    rdata_nxt[SRF_VEC_W-1:0] = vec_b;
                end
                default: begin
                    // Unmapped reads return zero
                    rdata_nxt = SRF_ZERO32;
                end
            endcase
        end
    end

    // Registers only
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            // No flags, all on level A, everything masked
            flag_r        <= SRF_FLAG_RST;
            level_r       <= SRF_LEVEL_RST;
            mask_r        <= SRF_MASK_RST;
            buf_r         <= '0;
            rdata_o       <= SRF_ZERO32;
            irq_o         <= 1'b0;
            irq_level_a_o <= 1'b0;
            irq_level_b_o <= 1'b0;
        end else begin
            // Every register loads on every edge
            flag_r        <= flag_nxt;
            level_r       <= level_nxt;
            mask_r        <= mask_nxt;
            buf_r         <= buf_nxt;
            rdata_o       <= rdata_nxt;
            irq_o         <= irq_nxt;
            irq_level_a_o <= irq_a_nxt;
            irq_level_b_o <= irq_b_nxt;
        end
    end
endmodule : srf_top
